// ---- hdl/mar_pkg.sv ----
// constants, field widths and timing counts for the monitor readout block
// assumes a single 200 MHz core clock with synchronous active-low reset
package mar_pkg;
    // result widths
    localparam int VMON_W = 11;
    localparam int NUM_VMON = 10;
    localparam int CHAN_W = 4;
    localparam int SHUNT_W = 12;
    localparam int SHUNT_SIGN_BIT = 11;
    localparam int TEMP_W = 9;
    localparam int RANGE_W = 3;

    // voltage monitor channel map
    localparam logic [3:0] CH_SENSE_POS_A = 4'h0;
    localparam logic [3:0] CH_SENSE_POS_B = 4'h1;
    localparam logic [3:0] CH_EXT_INPUT_0 = 4'h2;
    localparam logic [3:0] CH_EXT_INPUT_1 = 4'h3;
    localparam logic [3:0] CH_CORE_SUPPLY = 4'h4;
    localparam logic [3:0] CH_IO_SUPPLY = 4'h5;
    localparam logic [3:0] CH_ANALOG_SUPPLY_A = 4'h6;
    localparam logic [3:0] CH_ANALOG_SUPPLY_B = 4'h7;
    localparam logic [3:0] CH_REF_A = 4'h8;
    localparam logic [3:0] CH_REF_B = 4'h9;
    localparam logic [3:0] CH_FIRST = CH_SENSE_POS_A;
    localparam logic [3:0] CH_LAST = CH_REF_B;

    // reference used by software scaling, microvolts
    localparam int VMON_VREF_UV = 1213000;

    // shunt full-scale codes, 15 mV doubling to 240 mV
    localparam logic [2:0] RANGE_15MV = 3'h0;
    localparam logic [2:0] RANGE_30MV = 3'h1;
    localparam logic [2:0] RANGE_60MV = 3'h2;
    localparam logic [2:0] RANGE_120MV = 3'h3;
    localparam logic [2:0] RANGE_240MV = 3'h4;
    localparam int SHUNT_LSB_NV_15MV = 9400;

    // temperature scaling: gain in micro-degrees, offset in milli-degrees
    localparam int TEMP_GAIN_MILLI_MC = 764800;
    localparam int TEMP_OFFSET_MC = 80497;

    // reset values
    localparam logic [10:0] VMON_RESET = 11'h000;
    localparam logic [11:0] SHUNT_RESET = 12'h000;
    localparam logic [8:0] TEMP_RESET = 9'h000;

    // timing
    localparam int CLK_PERIOD_PS = 5000;
    localparam int TEMP_MAX_INTERVAL_MS = 5;
    // longest time: round down
    localparam int TEMP_INTERVAL_CYC =
        (TEMP_MAX_INTERVAL_MS * 1000000) / (CLK_PERIOD_PS / 1000);

    typedef enum logic [0:0] {
        SEQ_IDLE = 1'b0,
        SEQ_CONV = 1'b1
    } mar_seq_state_t;
endpackage : mar_pkg

// ---- hdl/mar_vmon_seq.sv ----
// round-robin sequencer for the multiplexed voltage monitor converter
// assumes the converter answers each start with one done pulse
`timescale 1ns/100ps
`default_nettype none
module mar_vmon_seq
    import mar_pkg::*;
(
    input wire logic clk,
    input wire logic rstn,
    input wire logic enable,
    input wire logic conv_done,
    output logic start_q,
    output logic [CHAN_W-1:0] chan_q
);
    mar_seq_state_t state_q, state_d;
    logic start_d;
    logic [CHAN_W-1:0] chan_d;

    // next channel after the current one, wrapping at the last
    function automatic logic [CHAN_W-1:0] next_chan(
        input logic [CHAN_W-1:0] c);
        if (c >= CH_LAST) begin
            next_chan = CH_FIRST;
        end else begin
            next_chan = c + 4'h1;
        end
    endfunction

    // start a conversion whenever idle and enabled; advance on done
    always_comb begin
        state_d = state_q;
        start_d = 1'b0;
        chan_d = chan_q;
        case (state_q)
            SEQ_IDLE: begin
                if (enable) begin
                    start_d = 1'b1;
                    state_d = SEQ_CONV;
                end
            end
            SEQ_CONV: begin
                // an in-flight conversion finishes even after disable
                if (conv_done) begin
                    chan_d = next_chan(chan_q);
                    state_d = SEQ_IDLE;
                end
            end
            default: begin
                state_d = SEQ_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk) begin
        if (!rstn) begin
            state_q <= SEQ_IDLE;
            start_q <= 1'b0;
            chan_q <= CH_FIRST;
        end else begin
            state_q <= state_d;
            start_q <= start_d;
            chan_q <= chan_d;
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rstn);

    chan_wrap_a: assert property (
        conv_done && state_q == SEQ_CONV && chan_q == CH_LAST
        |=> chan_q == CH_FIRST)
        else $error("channel did not wrap to zero");
    chan_step_a: assert property (
        conv_done && state_q == SEQ_CONV && chan_q < CH_LAST
        |=> chan_q == $past(chan_q) + 4'h1)
        else $error("channel did not step by one");
    start_cycle_a: assert property (
        enable && state_q == SEQ_IDLE |=> start_q ##1 !start_q)
        else $error("enabled idle sequencer gave no single start");
    wrap_c: cover property (conv_done && chan_q == CH_LAST);
endmodule // mar_vmon_seq
`default_nettype wire

// ---- hdl/mar_readout.sv ----
// monitor readout: voltage monitor round robin, two shunt channels,
// die temperature code with software override while disabled
// assumes converters give one-cycle done pulses with data valid alongside
`timescale 1ns/100ps
`default_nettype none
module mar_readout
    import mar_pkg::*;
#(
    parameter int TEMP_INTERVAL = TEMP_INTERVAL_CYC
)
(
    input wire logic clk,
    input wire logic rstn,
    // voltage monitor converter
    input wire logic vmon_enable,
    input wire logic vmon_done,
    input wire logic [VMON_W-1:0] vmon_data,
    output logic vmon_start_q,
    output logic [CHAN_W-1:0] vmon_mux_sel_q,
    output logic [NUM_VMON-1:0][VMON_W-1:0] vmon_result_q,
    // shunt current converters
    input wire logic [RANGE_W-1:0] shunt_range_a,
    input wire logic [RANGE_W-1:0] shunt_range_b,
    input wire logic shunt_done_a,
    input wire logic [SHUNT_W-1:0] shunt_data_a,
    input wire logic shunt_done_b,
    input wire logic [SHUNT_W-1:0] shunt_data_b,
    output logic [RANGE_W-1:0] shunt_fs_sel_a_q,
    output logic [RANGE_W-1:0] shunt_fs_sel_b_q,
    output logic [SHUNT_W-1:0] shunt_result_a_q,
    output logic [SHUNT_W-1:0] shunt_result_b_q,
    output logic shunt_neg_a_q,
    output logic shunt_neg_b_q,
    // die temperature sensor
    input wire logic temp_sensor_enable,
    input wire logic temp_done,
    input wire logic [TEMP_W-1:0] temp_data,
    input wire logic temp_wr,
    input wire logic [TEMP_W-1:0] temp_wr_data,
    output logic temp_start_q,
    output logic [TEMP_W-1:0] temp_code_q
);
    localparam logic [19:0] TEMP_RELOAD = 20'(TEMP_INTERVAL - 1);

    logic [NUM_VMON-1:0][VMON_W-1:0] vmon_result_d;
    logic [RANGE_W-1:0] shunt_fs_sel_a_d, shunt_fs_sel_b_d;
    logic [SHUNT_W-1:0] shunt_result_a_d, shunt_result_b_d;
    logic shunt_neg_a_d, shunt_neg_b_d;
    logic temp_start_d;
    logic [TEMP_W-1:0] temp_code_d;
    logic [19:0] temp_cnt_q, temp_cnt_d;

    // unsupported range codes fall back to the widest scale, safest reading
    function automatic logic [RANGE_W-1:0] clamp_range(
        input logic [RANGE_W-1:0] r);
        if (r > RANGE_240MV) begin
            clamp_range = RANGE_240MV;
        end else begin
            clamp_range = r;
        end
    endfunction

    // sequencing of the multiplexed converter
    mar_vmon_seq u_seq (
        .clk(clk),
        .rstn(rstn),
        .enable(vmon_enable),
        .conv_done(vmon_done),
        .start_q(vmon_start_q),
        .chan_q(vmon_mux_sel_q)
    );

    // voltage results: whole raw code lands in the selected slot on done
    always_comb begin
        vmon_result_d = vmon_result_q;
        if (vmon_done) begin
            vmon_result_d[vmon_mux_sel_q] = vmon_data;
        end
    end

    always_ff @(posedge clk) begin
        if (!rstn) begin
            vmon_result_q <= {NUM_VMON{VMON_RESET}};
        end else begin
            vmon_result_q <= vmon_result_d;
        end
    end

    // shunt channels: independent capture, sign carried unchanged
    always_comb begin
        shunt_fs_sel_a_d = clamp_range(shunt_range_a);
        shunt_fs_sel_b_d = clamp_range(shunt_range_b);
        shunt_result_a_d = shunt_result_a_q;
        shunt_result_b_d = shunt_result_b_q;
        if (shunt_done_a) begin
            shunt_result_a_d = shunt_data_a;
        end
        if (shunt_done_b) begin
            shunt_result_b_d = shunt_data_b;
        end
        shunt_neg_a_d = shunt_result_a_d[SHUNT_SIGN_BIT];
        shunt_neg_b_d = shunt_result_b_d[SHUNT_SIGN_BIT];
    end

    always_ff @(posedge clk) begin
        if (!rstn) begin
            shunt_fs_sel_a_q <= RANGE_15MV;
            shunt_fs_sel_b_q <= RANGE_15MV;
            shunt_result_a_q <= SHUNT_RESET;
            shunt_result_b_q <= SHUNT_RESET;
            shunt_neg_a_q <= 1'b0;
            shunt_neg_b_q <= 1'b0;
        end else begin
            shunt_fs_sel_a_q <= shunt_fs_sel_a_d;
            shunt_fs_sel_b_q <= shunt_fs_sel_b_d;
            shunt_result_a_q <= shunt_result_a_d;
            shunt_result_b_q <= shunt_result_b_d;
            shunt_neg_a_q <= shunt_neg_a_d;
            shunt_neg_b_q <= shunt_neg_b_d;
        end
    end

    // temperature: periodic start, capture, override only while disabled
    always_comb begin
        temp_cnt_d = temp_cnt_q;
        temp_start_d = 1'b0;
        temp_code_d = temp_code_q;
        if (!temp_sensor_enable) begin
            temp_cnt_d = 20'h00000; // first start right after enable
        end else if (temp_cnt_q == 20'h00000) begin
            temp_start_d = 1'b1;
            temp_cnt_d = TEMP_RELOAD;
        end else begin
            temp_cnt_d = temp_cnt_q - 20'h00001;
        end
        // a write while enabled is dropped; software must disable first
        if (temp_sensor_enable && temp_done) begin
            temp_code_d = temp_data;
        end else if (!temp_sensor_enable && temp_wr) begin
            temp_code_d = temp_wr_data;
        end
    end

    // temp_code_q is also the compensation input, override included
    always_ff @(posedge clk) begin
        if (!rstn) begin
            temp_cnt_q <= 20'h00000;
            temp_start_q <= 1'b0;
            temp_code_q <= TEMP_RESET;
        end else begin
            temp_cnt_q <= temp_cnt_d;
            temp_start_q <= temp_start_d;
            temp_code_q <= temp_code_d;
        end
    end

    // helper: cycles since last start while enabled
    logic [20:0] gap_q, gap_d;
    always_comb begin
        if (!temp_sensor_enable || temp_start_q) begin
            gap_d = 21'h000000;
        end else begin
            gap_d = gap_q + 21'h000001;
        end
    end

    always_ff @(posedge clk) begin
        if (!rstn) begin
            gap_q <= 21'h000000;
        end else begin
            gap_q <= gap_d;
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rstn);

    // capture, hold and override checks on the voltage and shunt results, range selects and temperature code
    vmon_hold_a: assert property (
        !vmon_done |=> $stable(vmon_result_q))
        else $error("voltage results changed without done");
    vmon_store_a: assert property (
        vmon_done |=> vmon_result_q[$past(vmon_mux_sel_q)] == $past(vmon_data))
        else $error("voltage result not stored in its channel slot");
    shunt_a_cap_a: assert property (
        shunt_done_a |=> shunt_result_a_q == $past(shunt_data_a)
        && shunt_neg_a_q == $past(shunt_data_a[11]))
        else $error("shunt A result or sign wrong");
    shunt_b_hold_a: assert property (
        !shunt_done_b |=> $stable(shunt_result_b_q))
        else $error("shunt B result changed without done");
    shunt_b_cap_a: assert property (
        shunt_done_b |=> shunt_result_b_q == $past(shunt_data_b)
        && shunt_neg_b_q == $past(shunt_data_b[SHUNT_SIGN_BIT]))
        else $error("shunt B result or sign wrong");
    shunt_a_hold_a: assert property (
        !shunt_done_a |=> $stable(shunt_result_a_q) && $stable(shunt_neg_a_q))
        else $error("shunt A result changed without done");
    range_pass_a: assert property (
        shunt_range_b <= RANGE_240MV
        |=> shunt_fs_sel_b_q == $past(shunt_range_b))
        else $error("shunt B range not passed through");
    range_clamp_a: assert property (
        shunt_range_a > RANGE_240MV |=> shunt_fs_sel_a_q == RANGE_240MV)
        else $error("shunt A range not clamped");
    temp_update_a: assert property (
        temp_sensor_enable && temp_done |=> temp_code_q == $past(temp_data))
        else $error("temperature code not updated");
    temp_lock_a: assert property (
        temp_sensor_enable && !temp_done |=> $stable(temp_code_q))
        else $error("temperature code changed while enabled");
    temp_override_a: assert property (
        !temp_sensor_enable && temp_wr |=> temp_code_q == $past(temp_wr_data))
        else $error("override write not taken while disabled");
    temp_idle_a: assert property (
        !temp_sensor_enable && !temp_wr |=> $stable(temp_code_q))
        else $error("temperature code changed while disabled and idle");
    temp_interval_a: assert property (
        gap_q <= 21'(TEMP_INTERVAL))
        else $error("temperature refresh interval exceeded");

    override_c: cover property (!temp_sensor_enable && temp_wr);
    shunt_neg_c: cover property (shunt_done_a && shunt_data_a[11]);
    temp_conv_c: cover property (temp_start_q ##[1:20] temp_done);
    wr_refused_c: cover property (temp_sensor_enable && temp_wr);
endmodule // mar_readout
`default_nettype wire

// ---- tb/mar_conv_model.sv ----
// behavioural model of the voltage monitor converter and the die sensor
// assumes one start pulse per conversion; data lines invert when idle
`timescale 1ns/100ps
`default_nettype none
module mar_conv_model
    import mar_pkg::*;
(
    input wire logic clk,
    input wire logic slow,
    input wire logic vmon_start,
    input wire logic [CHAN_W-1:0] vmon_sel,
    input wire logic temp_start,
    input wire logic [TEMP_W-1:0] temp_val,
    output logic vmon_done,
    output logic [VMON_W-1:0] vmon_data,
    output logic temp_done,
    output logic [TEMP_W-1:0] temp_data
);
    int vcnt = -1;
    int tcnt = -1;
    logic [VMON_W-1:0] vlast = 11'h000;
    // converter: code tagged with channel so a wrong slot shows up
    always @(posedge clk) begin
        vmon_done <= 1'b0;
        vmon_data <= ~vlast; // stale code must never be mistaken for new
        if (vmon_start) begin
            vcnt <= slow ? 6 : 1;
        end else if (vcnt > 0) begin
            vcnt <= vcnt - 1;
        end else if (vcnt == 0) begin
            vlast <= 11'h0a0 + {7'h00, vmon_sel};
            vmon_data <= 11'h0a0 + {7'h00, vmon_sel};
            vmon_done <= 1'b1;
            vcnt <= -1;
        end
    end
    // die sensor: fixed short conversion time
    always @(posedge clk) begin
        temp_done <= 1'b0;
        temp_data <= ~temp_val;
        if (temp_start) begin
            tcnt <= 3;
        end else if (tcnt > 0) begin
            tcnt <= tcnt - 1;
        end else if (tcnt == 0) begin
            temp_data <= temp_val;
            temp_done <= 1'b1;
            tcnt <= -1;
        end
    end
endmodule // mar_conv_model
`default_nettype wire

// ---- tb/mar_readout_tb_top.sv ----
// self-checking bench for the monitor readout block
// assumes mar_conv_model answers converter and sensor starts
`timescale 1ns/100ps
`default_nettype none
module mar_readout_tb_top;
    import mar_pkg::*;
    localparam int TI = 16;
    logic clk = 1'b0, rstn = 1'b0, slow = 1'b0, vmon_enable = 1'b0;
    logic vmon_done, shunt_done_a = 1'b0, shunt_done_b = 1'b0;
    logic [VMON_W-1:0] vmon_data;
    logic [RANGE_W-1:0] rng_a = 3'h0, rng_b = 3'h0, fs_a, fs_b;
    logic [SHUNT_W-1:0] sd_a = 12'h000, sd_b = 12'h000, res_a, res_b;
    logic temp_en = 1'b0, temp_done, temp_wr = 1'b0, vstart, tstart;
    logic [TEMP_W-1:0] temp_data, twd = 9'h000, tval = 9'h035, tcode;
    logic [CHAN_W-1:0] sel;
    logic [NUM_VMON-1:0][VMON_W-1:0] vres;
    logic neg_a, neg_b;
    int num_errors = 0, tests_run = 0, n, jb;
    logic [SHUNT_W-1:0] tbl[6] = '{12'h000, 12'h001, 12'h7ff, 12'h800,
        12'hfff, 12'hffe};
    always #2.5 clk = ~clk;
    mar_readout #(.TEMP_INTERVAL(TI)) i_dut (.clk(clk), .rstn(rstn),
        .vmon_enable(vmon_enable), .vmon_done(vmon_done),
        .vmon_data(vmon_data), .vmon_start_q(vstart),
        .vmon_mux_sel_q(sel), .vmon_result_q(vres),
        .shunt_range_a(rng_a), .shunt_range_b(rng_b),
        .shunt_done_a(shunt_done_a), .shunt_data_a(sd_a),
        .shunt_done_b(shunt_done_b), .shunt_data_b(sd_b),
        .shunt_fs_sel_a_q(fs_a), .shunt_fs_sel_b_q(fs_b),
        .shunt_result_a_q(res_a), .shunt_result_b_q(res_b),
        .shunt_neg_a_q(neg_a), .shunt_neg_b_q(neg_b),
        .temp_sensor_enable(temp_en), .temp_done(temp_done),
        .temp_data(temp_data), .temp_wr(temp_wr), .temp_wr_data(twd),
        .temp_start_q(tstart), .temp_code_q(tcode));
    mar_conv_model i_model (.clk(clk), .slow(slow), .vmon_start(vstart),
        .vmon_sel(sel), .temp_start(tstart), .temp_val(tval),
        .vmon_done(vmon_done), .vmon_data(vmon_data),
        .temp_done(temp_done), .temp_data(temp_data));
    // codes of every width are compared as 12 bits, zero-extended except the reset code, padded low
    task automatic chk_code(input logic [11:0] got, exp, input string m);
        tests_run++;
        if (got !== exp) begin
            num_errors++;
            $display("MISMATCH %0t %s got %h exp %h", $time, m, got, exp);
        end
    endtask
    task automatic cyc(input int k);
        repeat (k) @(posedge clk);
        #1;
    endtask
    // bounded wait for a start pulse; a miss counts as a mismatch
    task automatic wait_pulse(input bit tmp);
        for (n = 1; n < 200 && (tmp ? tstart : vstart) !== 1'b1; n++) cyc(1);
        chk_code({11'h000, tmp ? tstart : vstart}, 12'h001, "start");
    endtask
    task automatic test_done;
        $display("checks %0d errors %0d", tests_run, num_errors);
        if (num_errors == 0 && tests_run > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    initial begin
        #20000;
        num_errors++;
        test_done();
    end
    initial begin
        cyc(5);
        rstn = 1'b1;
        chk_code({vres[0], 1'b0}, 12'h000, "reset");
        // round robin over twelve starts, slow answers from the sixth on
        vmon_enable = 1'b1;
        for (int i = 0; i < 12; i++) begin
            slow = (i > 4);
            wait_pulse(1'b0);
            chk_code({8'h00, sel}, 12'(i % 10), "chan order");
            cyc(1);
        end
        vmon_enable = 1'b0;
        cyc(20);
        for (int i = 0; i < 10; i++)
            chk_code({1'b0, vres[i]}, 12'h0a0 + 12'(i), "slot");
        // shunt results back to back, each channel on its own
        for (int i = 0; i <= 6; i++) begin
            jb = (i > 5) ? 4 : i - 1; // b saw no done in the last step
            if (i > 0) begin
                chk_code(res_a, tbl[i-1], "shunt a");
                chk_code(res_b, ~tbl[jb], "shunt b");
                chk_code(12'(neg_a), 12'(tbl[i-1][11]), "neg");
                chk_code(12'(neg_b), 12'(!tbl[jb][11]), "neg b");
            end
            shunt_done_a = (i < 6);
            shunt_done_b = (i < 5);
            sd_a = tbl[i % 6];
            sd_b = ~tbl[i % 6];
            cyc(1);
        end
        chk_code(res_b, ~tbl[4], "b held");
        // every full-scale code, top ones clamped
        for (int r = 0; r < 8; r++) begin
            rng_a = 3'(r);
            rng_b = 3'(7 - r);
            cyc(1);
            chk_code(12'(fs_a), 12'(r > 4 ? 4 : r), "fs a");
            chk_code(12'(fs_b), 12'(r < 3 ? 4 : 7 - r), "fs b");
        end
        // sensor: refresh interval, new code, override refused
        temp_en = 1'b1;
        wait_pulse(1'b1);
        cyc(6);
        chk_code({3'h0, tcode}, 12'h035, "temp");
        tval = 9'h11b;
        temp_wr = 1'b1;
        twd = 9'h0aa;
        cyc(1);
        temp_wr = 1'b0;
        chk_code({3'h0, tcode}, 12'h035, "wr refused");
        wait_pulse(1'b1);
        chk_code(12'(n + 6), 12'(TI), "interval");
        cyc(6);
        chk_code({3'h0, tcode}, 12'h11b, "refresh");
        temp_en = 1'b0;
        cyc(8);
        temp_wr = 1'b1;
        twd = 9'h13c;
        cyc(1);
        temp_wr = 1'b0;
        chk_code({3'h0, tcode}, 12'h13c, "override");
        test_done();
    end
endmodule // mar_readout_tb_top
`default_nettype wire
